/* File: core/istc_ctrl.sv */
`timescale 1ns/1ps
// Operation
// RL1 - Filter code A, 9, 8 selects oversampling
// RL2 - Rate codes 12.5 Hz to 1600 Hz
// RL3 - Rate part has eight bandwidth settings
// RL4 - Self-test codes 0D, 09, 00 set polarity
// RL5 - Self-test adds static offset to samples
// RL6 - Host sets wide range and A7 first
// RL7 - Config bit 7, bandwidth high, rate low
// RL8 - Host waits 2 ms and 50 ms
// RL9 - Host checks difference thresholds per axis
// RL10 - Host resets or re-arms interrupts afterwards
// RL11 - Bit 0 starts test, 1 ready, 2 fail
// RL12 - Bit 4 shows background check good
// RL13 - Data flag set on new sample, self-clearing
// RL14 - Accel interrupt routed to pins a, b
// RL15 - Rate interrupt held 280 to 400 us
// RL16 - Rate interrupt off until 0x80 written
// RL17 - Rate interrupt routed to pins c, d
// RL18 - Command B6 starts part soft reset
// RL19 - Soft reset restores defaults after delay
// RL20 - Separate 8-bit map per chip select
// RL21 - Host uses read-modify-write on mixed registers
// RL22 - Interrupt only after whole sample stored
// RL23 - Low byte read freezes high byte
// RL24 - Invalid config reports error code 1
// RL25 - Other values in reset register ignored
// RL26 - Test start clears ready and fail
module istc_ctrl
    import istc_pkg::*;
#(
    parameter int          HOLD_CYC  = RATE_IRQ_HOLD_CYC,
    parameter logic [15:0] ST_OFFSET = 16'h1000
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_spi_sck,
    input  wire logic        i_cs_acc_n,
    input  wire logic        i_cs_rate_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    output logic             o_spi_miso_oe,
    input  wire logic [15:0] i_acc_x,
    input  wire logic [15:0] i_acc_y,
    input  wire logic [15:0] i_acc_z,
    input  wire logic        i_acc_valid,
    input  wire logic [15:0] i_rate_x,
    input  wire logic [15:0] i_rate_y,
    input  wire logic [15:0] i_rate_z,
    input  wire logic        i_rate_valid,
    input  wire logic        i_rate_bist_fail,
    input  wire logic        i_rate_bg_ok,
    output logic      [3:0]  o_acc_odr,
    output logic      [1:0]  o_acc_osr,
    output logic             o_acc_cont,
    output logic      [1:0]  o_acc_range,
    output logic             o_acc_st_en,
    output logic             o_acc_st_pos,
    output logic      [2:0]  o_rate_bw,
    output logic             o_irq_pin_a,
    output logic             o_irq_pin_a_oe,
    output logic             o_irq_pin_b,
    output logic             o_irq_pin_b_oe,
    output logic             o_irq_pin_c,
    output logic             o_irq_pin_c_oe,
    output logic             o_irq_pin_d,
    output logic             o_irq_pin_d_oe
);
    typedef enum logic {BIST_IDLE, BIST_RUN} istc_bist_type;

    logic        cs_idle;
    logic [4:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  addr_r;
    logic [7:0]  wdata_r;
    logic        part_r;
    logic        rd_tgl_r;
    logic        rd_frame_r;
    logic        wr_tgl_r;
    logic [7:0]  miso_sh_r;
    logic [1:0]  tgl_sync;
    logic [1:0]  tgl_seen_r;
    logic        rd_ev, wr_ev, wr_acc, wr_rate;
    logic [7:0]  rd_byte, rd_data_r;
    logic        acc_rst, rate_rst;
    logic [1:0]  srst_go_r;
    logic [7:0]  accel_filter_rate_config_r, acc_range_r, acc_st_r;
    logic [7:0]  acc_map_r, acc_io1_r, acc_io2_r;
    logic [7:0]  rate_bw_r, rate_ictl_r, rate_map_r, rate_ioconf_r;
    logic [15:0] acc_data_r [3];
    logic [15:0] rate_data_r [3];
    logic [7:0]  acc_shadow_r, rate_shadow_r;
    logic [15:0] st_adj;
    logic        conf_bad;
    logic [2:0]  acc_err_r;
    logic        acc_drdy_r, acc_stat_drdy_r;
    logic        rate_irq_r;
    logic [31:0] hold_cnt_r;
    istc_bist_type bist_r;
    logic [7:0]  bist_cnt_r;
    logic        bist_rdy_r, bist_fail_r, bg_ok_r;
    logic        in_data;
    logic [1:0]  axis;

    // Link side: mode 0, address byte, then write data or dummy+read data
    assign cs_idle = i_cs_acc_n & i_cs_rate_n;

    always_ff @(posedge i_spi_sck or posedge cs_idle) begin
        if (cs_idle) begin
            bit_cnt_r <= 5'h00;
            shift_r   <= 8'h00;
        end else begin
            shift_r <= {shift_r[6:0], i_spi_mosi};
            if (bit_cnt_r != FR_SAT) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge i_spi_sck) begin
        if (!cs_idle && bit_cnt_r == FR_ADDR_END) begin
            addr_r     <= {1'b0, shift_r[5:0], i_spi_mosi};
            part_r     <= i_cs_acc_n; // [RL20]
            rd_frame_r <= shift_r[6];
        end
        if (!cs_idle && bit_cnt_r == FR_WR_END && !rd_frame_r) begin
            wdata_r <= {shift_r[6:0], i_spi_mosi};
        end
    end

    // Event toggles cleared by system reset while the link clock stands
    always_ff @(posedge i_spi_sck or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_tgl_r <= 1'b0;
            wr_tgl_r <= 1'b0;
        end else if (!cs_idle) begin
            if (bit_cnt_r == FR_ADDR_END && shift_r[6]) begin
                rd_tgl_r <= ~rd_tgl_r;
            end
            if (bit_cnt_r == FR_WR_END && !rd_frame_r) begin
                wr_tgl_r <= ~wr_tgl_r;
            end
        end
    end

    always_ff @(negedge i_spi_sck or posedge cs_idle) begin
        if (cs_idle) begin
            miso_sh_r <= 8'h00;
        end else if (bit_cnt_r == FR_RD_LOAD) begin
            miso_sh_r <= rd_data_r;
        end else begin
            miso_sh_r <= {miso_sh_r[6:0], 1'b0};
        end
    end

    assign o_spi_miso    = miso_sh_r[7];
    assign o_spi_miso_oe = ~cs_idle;

    // Toggle events into the system clock
    istc_sync2 #(.W(2)) u_tgl_sync (
        .i_clk (i_ref_clk),
        .i_rst (i_sys_rst),
        .i_d   ({wr_tgl_r, rd_tgl_r}),
        .o_q   (tgl_sync)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            tgl_seen_r <= 2'h0;
        end else begin
            tgl_seen_r <= tgl_sync;
        end
    end

    assign rd_ev   = tgl_sync[0] ^ tgl_seen_r[0];
    assign wr_ev   = tgl_sync[1] ^ tgl_seen_r[1];
    assign wr_acc  = wr_ev & ~part_r;
    assign wr_rate = wr_ev & part_r;

    // Soft reset per part: 0 accel, 1 rate
    for (genvar p = 0; p < 2; p++) begin : g_srst
        logic [7:0] cnt_r;
        logic       busy_r;
        logic       hit;
        assign hit = (p == 0) ? (wr_acc && addr_r == A_SRST)
                              : (wr_rate && addr_r == R_SRST);
        always_ff @(posedge i_ref_clk) begin
            if (i_sys_rst) begin
                busy_r       <= 1'b0;
                cnt_r        <= 8'h00;
                srst_go_r[p] <= 1'b0;
            end else begin
                srst_go_r[p] <= 1'b0;
                if (hit && wdata_r == SRST_CMD) begin // [RL18] [RL25]
                    busy_r <= 1'b1;
                    cnt_r  <= 8'h00;
                end else if (busy_r) begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'(SRST_DELAY_CYC - 1)) begin
                        busy_r       <= 1'b0;
                        srst_go_r[p] <= 1'b1; // [RL19]
                    end
                end
            end
        end
    end

    assign acc_rst  = i_sys_rst | srst_go_r[0];
    assign rate_rst = i_sys_rst | srst_go_r[1];

    // Accelerometer configuration
    always_ff @(posedge i_ref_clk) begin
        if (acc_rst) begin
            accel_filter_rate_config_r  <= CONF_RST;
            acc_range_r <= RANGE_RST;
            acc_st_r    <= ZERO_RST;
            acc_map_r   <= ZERO_RST;
            acc_io1_r   <= ZERO_RST;
            acc_io2_r   <= ZERO_RST;
        end else if (wr_acc) begin
            unique case (addr_r)
                A_CONF:  accel_filter_rate_config_r  <= wdata_r; // [RL7]
                A_RANGE: acc_range_r <= wdata_r;
                A_ST:    acc_st_r    <= wdata_r; // [RL4]
                A_MAP:   acc_map_r   <= wdata_r;
                A_IO1:   acc_io1_r   <= wdata_r;
                A_IO2:   acc_io2_r   <= wdata_r;
                default: ;
            endcase
        end
    end

    assign conf_bad = !(accel_filter_rate_config_r[7:4] inside {BWP_NORM, BWP_OVERSAMPLE_TWOFOLD,
                                               BWP_OVERSAMPLE_FOURFOLD})
                   || accel_filter_rate_config_r[3:0] < ODR_MIN
                   || accel_filter_rate_config_r[3:0] > ODR_MAX;

    always_ff @(posedge i_ref_clk) begin
        if (acc_rst) begin
            acc_err_r <= 3'h0;
        end else begin
            acc_err_r <= conf_bad ? ERR_CONF : 3'h0; // [RL24]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (acc_rst) begin
            o_acc_odr <= CONF_RST[3:0];
            o_acc_osr <= 2'h0;
            o_acc_cont <= CONF_RST[CONT_BIT];
        end else if (!conf_bad) begin
            o_acc_odr  <= accel_filter_rate_config_r[3:0]; // [RL2]
            o_acc_osr  <= 2'(BWP_NORM - accel_filter_rate_config_r[7:4]); // [RL1]
            o_acc_cont <= accel_filter_rate_config_r[CONT_BIT]; // [RL7]
        end
    end

    assign o_acc_range  = acc_range_r[1:0];
    assign o_acc_st_en  = acc_st_r[ST_EN_BIT];
    assign o_acc_st_pos = acc_st_r[ST_POS_BIT];
    assign st_adj = !acc_st_r[ST_EN_BIT] ? 16'h0000
                  : acc_st_r[ST_POS_BIT] ? ST_OFFSET
                  : 16'h0000 - ST_OFFSET;

    // Sample storage and high-byte shadowing
    assign in_data = part_r ? (addr_r >= R_DATA0 && addr_r <= R_DATA0 +
                               DATA_SPAN)
                            : (addr_r >= A_DATA0 && addr_r <= A_DATA0 +
                               DATA_SPAN);
    assign axis = addr_r[2:1] - 2'h1;

    always_ff @(posedge i_ref_clk) begin
        if (acc_rst) begin
            acc_data_r <= '{3{16'h0000}};
        end else if (i_acc_valid) begin
            acc_data_r[0] <= i_acc_x + st_adj; // [RL5]
            acc_data_r[1] <= i_acc_y + st_adj;
            acc_data_r[2] <= i_acc_z + st_adj;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (rate_rst) begin
            rate_data_r <= '{3{16'h0000}};
        end else if (i_rate_valid) begin
            rate_data_r[0] <= i_rate_x;
            rate_data_r[1] <= i_rate_y;
            rate_data_r[2] <= i_rate_z;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            acc_shadow_r  <= 8'h00;
            rate_shadow_r <= 8'h00;
        end else if (rd_ev && in_data && !addr_r[0]) begin
            if (part_r) begin
                rate_shadow_r <= rate_data_r[axis][15:8]; // [RL23]
            end else begin
                acc_shadow_r <= acc_data_r[axis][15:8]; // [RL23]
            end
        end
    end

    // New-data flags: set beats the read that clears them
    always_ff @(posedge i_ref_clk) begin
        if (acc_rst) begin
            acc_drdy_r      <= 1'b0;
            acc_stat_drdy_r <= 1'b0;
        end else begin
            if (i_acc_valid) begin
                acc_drdy_r <= 1'b1; // [RL13] [RL22]
            end else if (rd_ev && !part_r && addr_r == A_ISTAT) begin
                acc_drdy_r <= 1'b0; // [RL13]
            end
            if (i_acc_valid) begin
                acc_stat_drdy_r <= 1'b1;
            end else if (rd_ev && !part_r && in_data) begin
                acc_stat_drdy_r <= 1'b0;
            end
        end
    end

    // Rate configuration
    always_ff @(posedge i_ref_clk) begin
        if (rate_rst) begin
            rate_bw_r     <= ZERO_RST;
            rate_ictl_r   <= ZERO_RST;
            rate_map_r    <= ZERO_RST;
            rate_ioconf_r <= ZERO_RST;
        end else if (wr_rate) begin
            unique case (addr_r)
                R_BW:      rate_bw_r     <= wdata_r;
                R_INTCTRL: rate_ictl_r   <= wdata_r; // [RL16]
                R_MAP:     rate_map_r    <= wdata_r;
                R_IOCONF:  rate_ioconf_r <= wdata_r;
                default: ;
            endcase
        end
    end

    assign o_rate_bw = rate_bw_r[2:0]; // [RL3]

    // Rate interrupt held for a fixed time after each stored sample
    always_ff @(posedge i_ref_clk) begin
        if (rate_rst) begin
            rate_irq_r <= 1'b0;
            hold_cnt_r <= 32'h0;
        end else if (i_rate_valid && rate_ictl_r[RIRQ_EN_BIT]) begin
            rate_irq_r <= 1'b1; // [RL15] [RL16] [RL22]
            hold_cnt_r <= 32'h0;
        end else if (rate_irq_r) begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
            if (hold_cnt_r == 32'(HOLD_CYC - 1)) begin
                rate_irq_r <= 1'b0; // [RL15]
            end
        end
    end

    // Rate built-in test
    always_ff @(posedge i_ref_clk) begin
        if (rate_rst) begin
            bist_r      <= BIST_IDLE;
            bist_cnt_r  <= 8'h00;
            bist_rdy_r  <= 1'b0;
            bist_fail_r <= 1'b0;
            bg_ok_r     <= 1'b0;
        end else begin
            bg_ok_r <= i_rate_bg_ok; // [RL12]
            unique case (bist_r)
                BIST_IDLE: begin
                    if (wr_rate && addr_r == R_ST &&
                        wdata_r[BIST_TRIG_BIT]) begin
                        bist_r      <= BIST_RUN; // [RL11]
                        bist_cnt_r  <= 8'h00;
                        bist_rdy_r  <= 1'b0; // [RL26]
                        bist_fail_r <= 1'b0;
                    end
                end
                BIST_RUN: begin
                    bist_cnt_r <= bist_cnt_r + 8'h01;
                    if (bist_cnt_r == 8'(BIST_CYC - 1)) begin
                        bist_r      <= BIST_IDLE;
                        bist_rdy_r  <= 1'b1; // [RL11]
                        bist_fail_r <= i_rate_bist_fail;
                    end
                end
            endcase
        end
    end

    // Read data, captured while the dummy byte passes
    always_comb begin
        rd_byte = 8'h00;
        if (in_data) begin
            rd_byte = addr_r[0] ? (part_r ? rate_shadow_r : acc_shadow_r)
                    : (part_r ? rate_data_r[axis][7:0]
                              : acc_data_r[axis][7:0]);
        end else if (!part_r) begin
            unique case (addr_r)
                A_ERR:    rd_byte = {3'h0, acc_err_r, 2'h0};
                A_STATUS: rd_byte = {acc_stat_drdy_r, 7'h00};
                A_ISTAT:  rd_byte = {acc_drdy_r, 7'h00};
                A_CONF:   rd_byte = accel_filter_rate_config_r;
                A_RANGE:  rd_byte = acc_range_r;
                A_ST:     rd_byte = acc_st_r;
                A_MAP:    rd_byte = acc_map_r;
                A_IO1:    rd_byte = acc_io1_r;
                A_IO2:    rd_byte = acc_io2_r;
                default:  rd_byte = 8'h00;
            endcase
        end else begin
            unique case (addr_r)
                R_BW:      rd_byte = rate_bw_r;
                R_INTCTRL: rd_byte = rate_ictl_r;
                R_MAP:     rd_byte = rate_map_r;
                R_IOCONF:  rd_byte = rate_ioconf_r;
                R_ST:      rd_byte = {3'h0, bg_ok_r, 1'b0, bist_fail_r,
                                      bist_rdy_r, bist_r == BIST_RUN};
                default:   rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rd_data_r <= 8'h00;
        end else if (rd_ev) begin
            rd_data_r <= rd_byte;
        end
    end

    // Interrupt pins
    istc_irq_pin u_pin_a (
        .i_evt         (acc_drdy_r & acc_map_r[MAP_A_BIT]), // [RL14]
        .i_drive_en    (acc_io1_r[IO_OUT_BIT]),
        .i_open_drain  (acc_io1_r[IO_OD_BIT]),
        .i_active_high (acc_io1_r[IO_LVL_BIT]),
        .o_pin         (o_irq_pin_a),
        .o_pin_oe      (o_irq_pin_a_oe)
    );
    istc_irq_pin u_pin_b (
        .i_evt         (acc_drdy_r & acc_map_r[MAP_B_BIT]), // [RL14]
        .i_drive_en    (acc_io2_r[IO_OUT_BIT]),
        .i_open_drain  (acc_io2_r[IO_OD_BIT]),
        .i_active_high (acc_io2_r[IO_LVL_BIT]),
        .o_pin         (o_irq_pin_b),
        .o_pin_oe      (o_irq_pin_b_oe)
    );
    istc_irq_pin u_pin_c (
        .i_evt         (rate_irq_r & rate_map_r[MAP_C_BIT]), // [RL17]
        .i_drive_en    (1'b1),
        .i_open_drain  (rate_ioconf_r[1]),
        .i_active_high (rate_ioconf_r[0]),
        .o_pin         (o_irq_pin_c),
        .o_pin_oe      (o_irq_pin_c_oe)
    );
    istc_irq_pin u_pin_d (
        .i_evt         (rate_irq_r & rate_map_r[MAP_D_BIT]), // [RL17]
        .i_drive_en    (1'b1),
        .i_open_drain  (rate_ioconf_r[3]),
        .i_active_high (rate_ioconf_r[2]),
        .o_pin         (o_irq_pin_d),
        .o_pin_oe      (o_irq_pin_d_oe)
    );

    // Checks
    localparam int BIST_MAX = 40;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_bist_start;
        wr_rate && addr_r == R_ST && wdata_r[0] && bist_r == BIST_IDLE;
    endsequence

    a_conf_error: assert property (##1 (acc_err_r == ERR_CONF) == // [RL24]
        $past(conf_bad) || $past(acc_rst)) else $error("conf error");
    a_st_offset: assert property (i_acc_valid && acc_st_r == 8'h0D // [RL5]
        && !acc_rst |=> acc_data_r[0] == $past(i_acc_x) + ST_OFFSET)
        else $error("self-test offset");
    a_drdy_set: assert property (i_acc_valid && !acc_rst // [RL13]
        |=> acc_drdy_r && acc_stat_drdy_r) else $error("drdy");
    a_rate_gate: assert property (!rate_ictl_r[7] && !rate_irq_r // [RL16]
        |=> !rate_irq_r) else $error("rate irq gate");
    a_rate_hold: assert property ($rose(rate_irq_r) // [RL15]
        |-> rate_irq_r[*8]) else $error("rate irq hold");
    a_rate_limit: assert property (rate_irq_r |-> // [RL15]
        hold_cnt_r < 32'(HOLD_CYC)) else $error("rate irq long");
    a_srst_other: assert property (wr_acc && addr_r == A_SRST // [RL25]
        && wdata_r != SRST_CMD && !g_srst[0].busy_r
        |=> !g_srst[0].busy_r) else $error("soft reset value");
    a_srst_dflt: assert property (srst_go_r[0] |=> // [RL19]
        accel_filter_rate_config_r == CONF_RST && acc_range_r == RANGE_RST)
        else $error("soft reset defaults");
    a_bist_clear: assert property (s_bist_start and !rate_rst // [RL26]
        |=> !bist_rdy_r && !bist_fail_r) else $error("bist clear");
    a_bist_done: assert property (s_bist_start and !rate_rst // [RL11]
        |-> ##[1:BIST_MAX] bist_rdy_r) else $error("bist done");
    a_bg_flag: assert property (!rate_rst |=> // [RL12]
        bg_ok_r == $past(i_rate_bg_ok)) else $error("background flag");
endmodule // istc_ctrl

/* File: core/istc_pkg.sv */
package istc_pkg;
    // Timing
    localparam int CLK_MHZ           = 125;
    localparam int CLK_PERIOD_NS     = 8;
    localparam int RATE_IRQ_HOLD_US  = 280;
    localparam int RATE_IRQ_HOLD_CYC = RATE_IRQ_HOLD_US * CLK_MHZ;
    localparam int SRST_DELAY_NS     = 200;
    localparam int SRST_DELAY_CYC    =
        (SRST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIST_NS           = 240;
    localparam int BIST_CYC          =
        (BIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Link frame positions (rising edges counted from zero)
    localparam logic [4:0] FR_ADDR_END = 5'h07;
    localparam logic [4:0] FR_WR_END   = 5'h0F;
    localparam logic [4:0] FR_RD_LOAD  = 5'h10;
    localparam logic [4:0] FR_SAT      = 5'h1F;
    // Accelerometer map
    localparam logic [7:0] A_ERR    = 8'h02;
    localparam logic [7:0] A_STATUS = 8'h03;
    localparam logic [7:0] A_DATA0  = 8'h12;
    localparam logic [7:0] A_ISTAT  = 8'h1D;
    localparam logic [7:0] A_CONF   = 8'h40;
    localparam logic [7:0] A_RANGE  = 8'h41;
    localparam logic [7:0] A_IO1    = 8'h53;
    localparam logic [7:0] A_IO2    = 8'h54;
    localparam logic [7:0] A_MAP    = 8'h58;
    localparam logic [7:0] A_ST     = 8'h6D;
    localparam logic [7:0] A_SRST   = 8'h7E;
    // Rate map
    localparam logic [7:0] R_DATA0   = 8'h02;
    localparam logic [7:0] R_BW      = 8'h10;
    localparam logic [7:0] R_SRST    = 8'h14;
    localparam logic [7:0] R_INTCTRL = 8'h15;
    localparam logic [7:0] R_IOCONF  = 8'h16;
    localparam logic [7:0] R_MAP     = 8'h18;
    localparam logic [7:0] R_ST      = 8'h3C;
    localparam logic [7:0] DATA_SPAN = 8'h05;
    // Reset values
    localparam logic [7:0] CONF_RST  = 8'hA8;
    localparam logic [7:0] RANGE_RST = 8'h01;
    localparam logic [7:0] ZERO_RST  = 8'h00;
    // Fields and codes
    localparam logic [3:0] BWP_NORM  = 4'hA;
    localparam logic [3:0] BWP_OVERSAMPLE_TWOFOLD  = 4'h9;
    localparam logic [3:0] BWP_OVERSAMPLE_FOURFOLD  = 4'h8;
    localparam logic [3:0] ODR_MIN   = 4'h5;
    localparam logic [3:0] ODR_MAX   = 4'hC;
    localparam int         CONT_BIT  = 7;
    localparam int         ST_EN_BIT = 0;
    localparam int         ST_POS_BIT = 2;
    localparam logic [7:0] SRST_CMD  = 8'hB6;
    localparam int         RIRQ_EN_BIT = 7;
    localparam int         BIST_TRIG_BIT = 0;
    localparam int         DRDY_BIT  = 7;
    localparam int         MAP_A_BIT = 2;
    localparam int         MAP_B_BIT = 6;
    localparam int         IO_OUT_BIT = 3;
    localparam int         IO_OD_BIT  = 2;
    localparam int         IO_LVL_BIT = 1;
    localparam int         MAP_C_BIT  = 0;
    localparam int         MAP_D_BIT  = 7;
    localparam logic [2:0] ERR_CONF   = 3'h1;
endpackage

/* File: core/istc_sync2.sv */
`timescale 1ns/1ps
module istc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // istc_sync2

/* File: core/istc_irq_pin.sv */
`timescale 1ns/1ps
module istc_irq_pin (
    input  wire logic i_evt,
    input  wire logic i_drive_en,
    input  wire logic i_open_drain,
    input  wire logic i_active_high,
    output logic      o_pin,
    output logic      o_pin_oe
);
    // Open drain drives only the low level
    always_comb begin
        o_pin    = i_active_high ? i_evt : ~i_evt;
        o_pin_oe = i_drive_en & (~i_open_drain | ~o_pin);
    end
endmodule // istc_irq_pin

/* File: bench/istc_host_model.sv */
`timescale 1ns/1ps
module istc_host_model (
    output logic      o_sck,
    output logic      o_cs_acc_n,
    output logic      o_cs_rate_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    initial {o_sck, o_cs_acc_n, o_cs_rate_n, o_mosi} = 4'h6;
    // One frame; clock idles low, data line toggles when unused
    task automatic xfer(input logic r, w, input logic [7:0] a, d,
                        output logic [7:0] q);
        logic [15:0] s;
        s = {~w, a[6:0], d};
        q = 8'h00;
        o_cs_acc_n = r;
        o_cs_rate_n = ~r;
        for (int i = 0; i < (w ? 16 : 24); i++) begin
            o_mosi = (i < 16) ? s[15-i] : ~o_mosi;
            #7.5 o_sck = 1'b1;
            if (i >= 16) q = {q[6:0], i_miso};
            #7.5 o_sck = 1'b0;
        end
        #7.5 {o_cs_acc_n, o_cs_rate_n, o_mosi} = {2'h3, ~o_mosi};
        #100;
    endtask
endmodule // istc_host_model

/* File: bench/imu_selftest_irq_reset_ctrl_bench.sv */
`timescale 1ns/1ps
module imu_selftest_irq_reset_ctrl_bench;
    import istc_pkg::*;
    localparam int HC = 20;
    localparam logic [7:0] STC [3] = '{8'h0D, 8'h09, 8'h00};
    localparam logic [7:0] STM [3] = '{8'h66, 8'h46, 8'h56};
    logic clk, rst, sck, csa_n, csr_n, mosi, miso, av, rv, bf;
    logic cont, sten, stp, pa, pa_oe, pb_oe, pc, bg;
    logic [15:0] ax;
    logic [7:0]  q, e;
    logic [3:0]  b, odr;
    logic [1:0]  oversampling_ratio, rng;
    logic [2:0]  bw;
    int          failures = 0;
    int          compares = 0;
    always #4 clk = ~clk;
    istc_host_model host (.o_sck(sck), .o_cs_acc_n(csa_n),
        .o_cs_rate_n(csr_n), .o_mosi(mosi), .i_miso(miso));
    istc_ctrl #(.HOLD_CYC(HC), .ST_OFFSET(16'h1000)) DUT (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_spi_sck(sck),
        .i_cs_acc_n(csa_n), .i_cs_rate_n(csr_n), .i_spi_mosi(mosi),
        .o_spi_miso(miso), .o_spi_miso_oe(), .i_acc_x(ax), .i_acc_y(ax),
        .i_acc_z(ax), .i_acc_valid(av), .i_rate_x(ax), .i_rate_y(ax),
        .i_rate_z(ax), .i_rate_valid(rv), .i_rate_bist_fail(bf),
        .i_rate_bg_ok(bg), .o_acc_odr(odr), .o_acc_osr(oversampling_ratio),
        .o_acc_cont(cont), .o_acc_range(rng), .o_acc_st_en(sten),
        .o_acc_st_pos(stp), .o_rate_bw(bw), .o_irq_pin_a(pa),
        .o_irq_pin_a_oe(pa_oe), .o_irq_pin_b(), .o_irq_pin_b_oe(pb_oe),
        .o_irq_pin_c(pc), .o_irq_pin_c_oe(), .o_irq_pin_d(),
        .o_irq_pin_d_oe());
    task automatic chk(input logic [7:0] g, x);
        compares++;
        if (g !== x) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic r, input logic [7:0] a, d);
        host.xfer(r, 1'b1, a, d, q);
    endtask
    task automatic rd(input logic r, input logic [7:0] a, x);
        host.xfer(r, 1'b0, a, 8'h00, q);
        chk(q, x);
    endtask
    task automatic pulse(input logic r);
        @(posedge clk) #1 {av, rv} = {~r, r};
        @(posedge clk) #1 {av, rv} = 2'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        {clk, rst, av, rv, bf, bg, ax} = {6'h13, 16'h0234};
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        rd(0, A_CONF, CONF_RST);
        chk({cont, oversampling_ratio, 1'b0, odr}, 8'h88);
        for (int j = 0; j < 8; j++) begin
            b = BWP_NORM - 4'(j % 3);
            e = {1'b1, 2'(j % 3), 1'b0, ODR_MIN + 4'(j)};
            wr(0, A_CONF, {b, ODR_MIN + 4'(j)});
            chk({cont, oversampling_ratio, 1'b0, odr}, e);
        end
        wr(0, A_CONF, 8'h73);
        rd(0, A_ERR, 8'h04);
        chk({cont, oversampling_ratio, 1'b0, odr}, e);
        wr(0, A_RANGE, 8'h03);
        wr(0, A_CONF, 8'hA7);
        $display("config test ended");
        wr(0, A_MAP, 8'h04);
        wr(0, A_IO1, 8'h0A);
        pulse(0);
        chk({5'h0, pb_oe, pa, pa_oe}, 8'h03);
        rd(0, A_ISTAT, 8'h80);
        rd(0, A_ISTAT, 8'h00);
        rd(0, A_DATA0, 8'h34);
        ax = 16'h5678;
        pulse(0);
        rd(0, A_DATA0 + 8'h01, 8'h02);
        wr(0, A_ST, 8'h0D);
        pulse(0);
        rd(0, A_DATA0, 8'h78);
        rd(0, A_DATA0 + 8'h01, 8'h66);
        foreach (STC[k]) begin
            wr(0, A_ST, STC[k]);
            chk({6'h0, sten, stp}, {6'h0, STC[k][0], STC[k][2]});
            pulse(0);
            rd(0, A_DATA0, 8'h78);
            rd(0, A_DATA0 + 8'h01, STM[k]);
            if (k == 0) e = q;
            if (k == 1) chk(e - q, 8'h20);
        end
        $display("accel test ended");
        wr(1, R_BW, 8'h07);
        chk({5'h0, bw}, 8'h07);
        wr(1, R_MAP, 8'h01);
        pulse(1);
        chk({7'h0, pc}, 8'h01);
        wr(1, R_INTCTRL, 8'h80);
        pulse(1);
        chk({7'h0, pc}, 8'h00);
        repeat (HC + 2) @(posedge clk);
        #1 chk({7'h0, pc}, 8'h01);
        for (int f = 1; f >= 0; f--) begin
            @(posedge clk) #1 {bf, bg} = {f[0], ~f[0]};
            wr(1, R_ST, 8'h01);
            repeat (40) @(posedge clk);
            host.xfer(1, 1'b0, R_ST, 8'h00, q);
            chk(q & 8'h16, {3'h0, ~f[0], 1'b0, f[0], 2'h2});
        end
        wr(0, A_SRST, 8'h55);
        repeat (40) @(posedge clk);
        #1 chk({6'h0, rng}, 8'h03);
        wr(0, A_SRST, SRST_CMD);
        wr(1, R_SRST, SRST_CMD);
        repeat (40) @(posedge clk);
        #1 chk({rng, 3'h0, bw}, {RANGE_RST[1:0], 6'h00});
        rd(0, A_CONF, CONF_RST);
        $display("rate and reset test ended");
        print_verdict();
    end
endmodule // imu_selftest_irq_reset_ctrl_bench
